// [core/ubu_consts.svh]
`ifndef UBU_CONSTS_SVH
`define UBU_CONSTS_SVH
`define UBU_CLK_HZ 50000000
`define UBU_DIV_INT_MIN 14'h0002
`define UBU_DIV_INT_MAX 15'h4000
`define UBU_DIV_INT_RST 14'h001A
`define UBU_DIV_FRAC_RST 3'h0
`define UBU_TX_DEPTH 128
`define UBU_RX_DEPTH 384
`define UBU_MS_US 1000
`define UBU_MS_CYC ((`UBU_CLK_HZ / 1000000) * `UBU_MS_US)
`define UBU_FLUSH_RST 8'h10
`define UBU_XON 8'h11
`define UBU_XOFF 8'h13
`endif

// [core/ubu_pkg.sv]
package ubu_pkg;
    typedef enum logic [1:0]
    {
        UBU_MODE_UART = 2'b00,
        UBU_MODE_ABB = 2'b01,
        UBU_MODE_SBB = 2'b10
    } ubu_mode_type;
    typedef enum logic [1:0]
    {
        UBU_FLOW_NONE = 2'b00,
        UBU_FLOW_RTSCTS = 2'b01,
        UBU_FLOW_DTRDSR = 2'b10,
        UBU_FLOW_XONXOFF = 2'b11
    } ubu_flow_type;
    typedef enum logic [1:0]
    {
        UBU_TX_IDLE = 2'b00,
        UBU_TX_START = 2'b01,
        UBU_TX_DATA = 2'b10,
        UBU_TX_STOP = 2'b11
    } ubu_tx_state_type;
    typedef struct packed
    {
        logic [13:0] div_int;
        logic [2:0] div_frac;
    } ubu_baud_type;
    typedef struct packed
    {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } ubu_modem_in_type;
endpackage : ubu_pkg

// [core/ubu_baud.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ubu_consts.svh"
module ubu_baud
    import ubu_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Divisor
    input wire ubu_baud_type i_div,
    // Oversample enable, one cycle
    output logic o_tick
);
    logic [14:0] cnt_q;
    logic [2:0] phase_q;
    logic [14:0] lim;
    logic extra;
    logic [14:0] n_eff;
    // Zero selects the top divisor, which fourteen bits cannot hold; one is clamped up
    assign n_eff = (i_div.div_int == 14'h0000) ? `UBU_DIV_INT_MAX
                 : (i_div.div_int < `UBU_DIV_INT_MIN) ? {1'b0, `UBU_DIV_INT_MIN}
                 : {1'b0, i_div.div_int};
    // Fraction f/8: f periods out of each eight get one extra cycle
    assign extra = ({1'b0, phase_q} < {1'b0, i_div.div_frac});
    assign lim = extra ? n_eff : n_eff - 15'h0001;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_q <= 15'h0000;
            phase_q <= 3'h0;
            o_tick <= 1'b0;
        end
        else if (cnt_q >= lim)
        begin
            cnt_q <= 15'h0000;
            phase_q <= phase_q + 3'h1;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 15'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule : ubu_baud
`default_nettype wire

// [core/ubu_skid.sv]
`timescale 1ns/1ps
`default_nettype none
module ubu_skid #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    // Two entries: a stall on the drain side costs no word
    logic [WIDTH-1:0] mem_q [0:1];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;
    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rp_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'd0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= ~wp_q;
            end
            if (pop)
            begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            mem_q[wp_q] <= i_data;
        end
    end
endmodule : ubu_skid
`default_nettype wire

// [core/ubu_channel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ubu_consts.svh"
module ubu_channel
    import ubu_pkg::*;
#(
    parameter int TX_DEPTH = `UBU_TX_DEPTH,
    parameter int RX_DEPTH = `UBU_RX_DEPTH,
    parameter int MS_CYC = `UBU_MS_CYC
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Configuration
    input wire ubu_mode_type i_mode,
    input wire ubu_flow_type i_flow,
    input wire ubu_baud_type i_div,
    input wire logic i_seven_bit,
    input wire logic i_break,
    input wire logic i_rts_set,
    input wire logic i_dtr_set,
    input wire logic [7:0] i_flush_ms,
    input wire logic [7:0] i_bb_dir,
    // USB out endpoint
    input wire logic i_out_valid,
    input wire logic [7:0] i_out_data,
    output logic o_out_ready,
    // USB in endpoint
    input wire logic i_in_req,
    output logic o_in_valid,
    output logic [7:0] o_in_data,
    output logic o_in_flush,
    // Serial side
    output logic o_txd,
    input wire logic i_rxd,
    output logic o_rts_n,
    output logic o_dtr_n,
    input wire ubu_modem_in_type i_modem_n,
    output logic o_line_driver_enable,
    output logic o_break_seen,
    output logic [3:0] o_modem_status,
    input wire logic i_send_now_wake_pin_n,
    // Bit-bang port
    input wire logic [7:0] i_bb,
    output logic [7:0] o_bb,
    output logic [7:0] o_bb_oe,
    output logic o_bb_wr_n,
    output logic o_bb_rd_n
);
    localparam int TXW = $clog2(TX_DEPTH);
    localparam int RXW = $clog2(RX_DEPTH + 1);

    // ----------------------------------------
    // Baud generator
    // ----------------------------------------
    logic tick;
    // Reference-to-divisor ratio sets the reachable 190..1.5625M range
    ubu_baud u_baud (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_div(i_div),
        .o_tick(tick)
    );

    // ----------------------------------------
    // Transmit buffer
    // ----------------------------------------
    logic [7:0] txm [0:TX_DEPTH-1];
    logic [TXW-1:0] twp_q;
    logic [TXW-1:0] trp_q;
    logic [TXW:0] tcnt_q;
    logic tx_take;
    logic tpush;
    assign tpush = i_out_valid && o_out_ready;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            twp_q <= '0;
            trp_q <= '0;
            tcnt_q <= '0;
            o_out_ready <= 1'b0;
        end
        else
        begin
            if (tpush)
            begin
                twp_q <= (twp_q == TXW'(TX_DEPTH - 1)) ? '0 : twp_q + 1'b1;
            end
            if (tx_take)
            begin
                trp_q <= (trp_q == TXW'(TX_DEPTH - 1)) ? '0 : trp_q + 1'b1;
            end
            tcnt_q <= tcnt_q + (TXW+1)'(tpush) - (TXW+1)'(tx_take);
            // Registered ready keeps one spare slot for the push in flight
            o_out_ready <= (tcnt_q + (TXW+1)'(tpush)) < (TXW+1)'(TX_DEPTH - 1);
        end
    end
    always_ff @(posedge i_mclk)
    begin
        if (tpush)
        begin
            txm[twp_q] <= i_out_data;
        end
    end
    logic tx_have;
    assign tx_have = (tcnt_q != '0);

    // ----------------------------------------
    // Flow control
    // ----------------------------------------
    logic xoff_q;
    logic tx_hold;
    always_comb
    begin
        case (i_flow)
            UBU_FLOW_RTSCTS: tx_hold = i_modem_n.cts;
            UBU_FLOW_DTRDSR: tx_hold = i_modem_n.dsr;
            UBU_FLOW_XONXOFF: tx_hold = xoff_q;
            default: tx_hold = 1'b0;
        endcase
    end

    // ----------------------------------------
    // UART transmitter
    // ----------------------------------------
    ubu_tx_state_type ts_q;
    logic [3:0] tsub_q;
    logic [2:0] tbit_q;
    logic [7:0] tsh_q;
    logic uart;
    assign uart = (i_mode == UBU_MODE_UART);
    logic tx_go;
    assign tx_go = uart && tick && ts_q == UBU_TX_IDLE && tx_have && !tx_hold && !i_break;
    logic abb_go;
    logic sbb_go;
    assign tx_take = tx_go || abb_go || sbb_go;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ts_q <= UBU_TX_IDLE;
            tsub_q <= 4'h0;
            tbit_q <= 3'h0;
            tsh_q <= 8'h00;
            o_txd <= 1'b1;
            o_line_driver_enable <= 1'b0;
        end
        else if (tick)
        begin
            tsub_q <= tsub_q + 4'h1;
            case (ts_q)
                UBU_TX_IDLE:
                begin
                    tsub_q <= 4'h0;
                    o_txd <= !i_break;
                    o_line_driver_enable <= tx_go;
                    if (tx_go)
                    begin
                        tsh_q <= txm[trp_q];
                        ts_q <= UBU_TX_START;
                        o_txd <= 1'b0;
                    end
                end
                UBU_TX_START:
                begin
                    if (tsub_q == 4'hF)
                    begin
                        ts_q <= UBU_TX_DATA;
                        tbit_q <= 3'h0;
                        o_txd <= tsh_q[0];
                    end
                end
                UBU_TX_DATA:
                begin
                    if (tsub_q == 4'hF)
                    begin
                        tsh_q <= {1'b1, tsh_q[7:1]};
                        tbit_q <= tbit_q + 3'h1;
                        o_txd <= tsh_q[1];
                        if (tbit_q == (i_seven_bit ? 3'h6 : 3'h7))
                        begin
                            ts_q <= UBU_TX_STOP;
                            o_txd <= 1'b1;
                        end
                    end
                end
                UBU_TX_STOP:
                begin
                    if (tsub_q == 4'hF)
                    begin
                        ts_q <= UBU_TX_IDLE;
                        // Stays on only if another byte follows at once
                        o_line_driver_enable <= tx_have && !tx_hold;
                    end
                end
                default: ts_q <= UBU_TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // UART receiver
    // ----------------------------------------
    logic [1:0] rs_q;
    logic [3:0] rsub_q;
    logic [2:0] rbit_q;
    logic [7:0] rsh_q;
    logic rx_push;
    logic [7:0] rx_byte;
    logic brk_zero_q;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rs_q <= 2'd0;
            rsub_q <= 4'h0;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rx_push <= 1'b0;
            rx_byte <= 8'h00;
            brk_zero_q <= 1'b0;
            o_break_seen <= 1'b0;
            xoff_q <= 1'b0;
        end
        else
        begin
            rx_push <= 1'b0;
            if (uart && tick)
            begin
                rsub_q <= rsub_q + 4'h1;
                case (rs_q)
                    2'd0:
                    begin
                        rsub_q <= 4'h0;
                        brk_zero_q <= 1'b1;
                        if (!i_rxd)
                        begin
                            rs_q <= 2'd1;
                        end
                        else
                        begin
                            o_break_seen <= 1'b0;
                        end
                    end
                    2'd1:
                    begin
                        if (rsub_q == 4'h7)
                        begin
                            rs_q <= i_rxd ? 2'd0 : 2'd2;
                            rsub_q <= 4'h0;
                            rbit_q <= 3'h0;
                        end
                    end
                    2'd2:
                    begin
                        if (rsub_q == 4'hF)
                        begin
                            rsh_q <= i_seven_bit ? {1'b0, i_rxd, rsh_q[6:1]}
                                                 : {i_rxd, rsh_q[7:1]};
                            brk_zero_q <= brk_zero_q && !i_rxd;
                            rbit_q <= rbit_q + 3'h1;
                            if (rbit_q == (i_seven_bit ? 3'h6 : 3'h7))
                            begin
                                rs_q <= 2'd3;
                            end
                        end
                    end
                    default:
                    begin
                        if (rsub_q == 4'hF)
                        begin
                            rs_q <= 2'd0;
                            if (i_rxd)
                            begin
                                rx_byte <= rsh_q;
                                rx_push <= !(i_flow == UBU_FLOW_XONXOFF &&
                                            (rsh_q == `UBU_XON || rsh_q == `UBU_XOFF));
                                if (rsh_q == `UBU_XOFF)
                                begin
                                    xoff_q <= 1'b1;
                                end
                                else if (rsh_q == `UBU_XON)
                                begin
                                    xoff_q <= 1'b0;
                                end
                            end
                            else if (brk_zero_q)
                            begin
                                // All-zero frame with low stop bit
                                o_break_seen <= 1'b1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Modem lines
    // ----------------------------------------
    logic [RXW-1:0] rcnt_q;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rts_n <= 1'b1;
            o_dtr_n <= 1'b1;
            o_modem_status <= 4'h0;
        end
        else
        begin
            // RTS/CTS and DTR/DSR flow modes drop ready when the receive buffer nears full
            o_rts_n <= !(i_rts_set && !(i_flow == UBU_FLOW_RTSCTS &&
                        rcnt_q > RXW'(RX_DEPTH - 32)));
            o_dtr_n <= !(i_dtr_set && !(i_flow == UBU_FLOW_DTRDSR &&
                        rcnt_q > RXW'(RX_DEPTH - 32)));
            o_modem_status <= ~i_modem_n;
        end
    end

    // ----------------------------------------
    // Bit-bang port
    // ----------------------------------------
    logic [3:0] bdiv_q;
    logic bb_push;
    logic [7:0] bb_byte;
    assign abb_go = (i_mode == UBU_MODE_ABB) && tick && bdiv_q == 4'hF && tx_have;
    assign sbb_go = (i_mode == UBU_MODE_SBB) && tick && bdiv_q == 4'hF && tx_have;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bdiv_q <= 4'h0;
            o_bb <= 8'h00;
            o_bb_oe <= 8'h00;
            o_bb_wr_n <= 1'b1;
            o_bb_rd_n <= 1'b1;
            bb_push <= 1'b0;
            bb_byte <= 8'h00;
        end
        else
        begin
            bb_push <= 1'b0;
            o_bb_wr_n <= 1'b1;
            o_bb_rd_n <= 1'b1;
            o_bb_oe <= uart ? 8'h00 : i_bb_dir;
            if (tick)
            begin
                bdiv_q <= bdiv_q + 4'h1;
            end
            if (abb_go || sbb_go)
            begin
                o_bb <= txm[trp_q];
                o_bb_wr_n <= 1'b0;
            end
            if (sbb_go)
            begin
                // Pin state captured with the write, so bytes pair up
                bb_byte <= i_bb;
                bb_push <= 1'b1;
            end
            else if ((i_mode == UBU_MODE_ABB) && tick && bdiv_q == 4'h7)
            begin
                bb_byte <= i_bb;
                bb_push <= 1'b1;
                o_bb_rd_n <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Receive path: two-entry buffer, then store
    // ----------------------------------------
    logic sk_valid;
    logic [7:0] sk_data;
    logic sk_ready;
    logic rfull;
    ubu_skid #(
        .WIDTH(8)
    ) u_skid (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_valid(rx_push || bb_push),
        .i_data(rx_push ? rx_byte : bb_byte),
        .o_ready(),
        .o_valid(sk_valid),
        .o_data(sk_data),
        .i_ready(sk_ready)
    );
    assign sk_ready = !rfull;
    logic [7:0] rxm [0:RX_DEPTH-1];
    logic [RXW-1:0] rwp_q;
    logic [RXW-1:0] rrp_q;
    logic rpush;
    logic rpop;
    assign rfull = (rcnt_q == RXW'(RX_DEPTH));
    assign rpush = sk_valid && sk_ready;
    assign rpop = i_in_req && (rcnt_q != '0);
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rwp_q <= '0;
            rrp_q <= '0;
            rcnt_q <= '0;
            o_in_valid <= 1'b0;
            o_in_data <= 8'h00;
        end
        else
        begin
            o_in_valid <= rpop;
            if (rpush)
            begin
                rwp_q <= (rwp_q == RXW'(RX_DEPTH - 1)) ? '0 : rwp_q + 1'b1;
            end
            if (rpop)
            begin
                o_in_data <= rxm[rrp_q];
                rrp_q <= (rrp_q == RXW'(RX_DEPTH - 1)) ? '0 : rrp_q + 1'b1;
            end
            rcnt_q <= rcnt_q + RXW'(rpush) - RXW'(rpop);
        end
    end
    always_ff @(posedge i_mclk)
    begin
        if (rpush)
        begin
            rxm[rwp_q] <= sk_data;
        end
    end

    // ----------------------------------------
    // Flush: send-now strobe and latency timer
    // ----------------------------------------
    logic [31:0] mscnt_q;
    logic [7:0] ms_q;
    logic sn_q;
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mscnt_q <= 32'h0000_0000;
            ms_q <= 8'h00;
            sn_q <= 1'b1;
            o_in_flush <= 1'b0;
        end
        else
        begin
            sn_q <= i_send_now_wake_pin_n;
            mscnt_q <= (mscnt_q >= 32'(MS_CYC - 1)) ? 32'h0000_0000 : mscnt_q + 32'h1;
            if (rcnt_q == '0 || rpush)
            begin
                ms_q <= 8'h00;
                mscnt_q <= 32'h0000_0000;
            end
            else if (mscnt_q >= 32'(MS_CYC - 1) && ms_q != 8'hFF)
            begin
                ms_q <= ms_q + 8'h01;
            end
            // Set beats clear: a new request held off until flush reaches host
            if (sn_q && !i_send_now_wake_pin_n)
            begin
                o_in_flush <= 1'b1;
            end
            else if (i_flush_ms != 8'h00 && ms_q >= i_flush_ms && rcnt_q != '0)
            begin
                o_in_flush <= 1'b1;
            end
            else if (i_in_req && rcnt_q == '0)
            begin
                o_in_flush <= 1'b0;
            end
        end
    end
endmodule : ubu_channel
`default_nettype wire

// [testbench/ubu_channel_props.sv]
`timescale 1ns/1ps
`default_nettype none
module ubu_channel_props
    import ubu_pkg::*;
(
    // Watched ports
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire ubu_mode_type i_mode,
    input wire logic i_break,
    input wire logic i_in_req,
    input wire ubu_modem_in_type i_modem_n,
    input wire logic i_send_now_wake_pin_n,
    input wire logic o_txd,
    input wire logic o_in_valid,
    input wire logic o_in_flush,
    input wire logic o_line_driver_enable,
    input wire logic [3:0] o_modem_status,
    input wire logic o_bb_wr_n,
    input wire logic o_bb_rd_n
);
    // ----
    // Checks
    // ----
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    modem_copy_a: assert property ($past(i_rst_n) |-> o_modem_status == ~$past(i_modem_n))
        else $error("modem status not inverted copy");
    idle_high_a: assert property (!o_line_driver_enable && !i_break && !$past(i_break) |-> o_txd)
        else $error("txd low outside frame");
    start_enable_a: assert property ($rose(o_line_driver_enable) |-> !o_txd)
        else $error("enable rise without start bit");
    pop_answer_a: assert property (o_in_valid |-> $past(i_in_req))
        else $error("in valid without request");
    wr_pulse_a: assert property (!o_bb_wr_n |=> o_bb_wr_n)
        else $error("write strobe too long");
    rd_pulse_a: assert property (!o_bb_rd_n |=> o_bb_rd_n)
        else $error("read strobe too long");
    uart_quiet_a: assert property (i_mode == UBU_MODE_UART && $past(i_mode) == UBU_MODE_UART
        |-> o_bb_wr_n && o_bb_rd_n)
        else $error("strobe in uart mode");
    send_now_a: assert property ($fell(i_send_now_wake_pin_n) |-> ##[1:2] o_in_flush)
        else $error("send now did not flush");
    cover property ($rose(o_line_driver_enable));
    cover property (o_in_valid);
    cover property (!o_bb_wr_n);
endmodule : ubu_channel_props
bind ubu_channel ubu_channel_props chk_u (.i_mclk, .i_rst_n, .i_mode, .i_break, .i_in_req,
    .i_modem_n, .i_send_now_wake_pin_n, .o_txd, .o_in_valid, .o_in_flush,
    .o_line_driver_enable, .o_modem_status, .o_bb_wr_n, .o_bb_rd_n);
`default_nettype wire

// [testbench/ubu_peer.sv]
`timescale 1ns/1ps
`default_nettype none
module ubu_peer #(
    parameter int BIT_CYC = 32
) (
    // Line
    input wire logic i_mclk,
    input wire logic i_txd,
    input wire logic i_seven,
    output logic o_rxd,
    // Decoded characters
    output logic o_valid,
    output logic [7:0] o_data
);
    // ----
    // Serial transceiver
    // ----
    logic [7:0] sh;
    initial
    begin
        o_rxd = 1'b1;
        o_valid = 1'b0;
        o_data = 8'h00;
    end
    // Samples mid-bit so a tick of skew cannot flip a bit
    always
    begin
        @(negedge i_txd);
        repeat (BIT_CYC / 2) @(posedge i_mclk);
        sh = 8'h00;
        for (int i = 0; i < (i_seven ? 7 : 8); i++)
        begin
            repeat (BIT_CYC) @(posedge i_mclk);
            sh[i] = i_txd;
        end
        repeat (BIT_CYC) @(posedge i_mclk);
        #1;
        o_data = sh;
        o_valid = 1'b1;
        @(posedge i_mclk);
        #1;
        o_valid = 1'b0;
    end
    task automatic send(input logic [7:0] v);
        logic [9:0] f;
        f = {1'b1, v, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            o_rxd = f[i];
            repeat (BIT_CYC) @(posedge i_mclk);
            #1;
        end
    endtask : send
    // Holds the line at a level, e.g. low for a break
    task automatic set_line(input logic v);
        o_rxd = v;
    endtask : set_line
endmodule : ubu_peer
`default_nettype wire

// [testbench/test_usb_bridge_uart_channel.sv]
`timescale 1ns/1ps
`default_nettype none
module test_usb_bridge_uart_channel
    import ubu_pkg::*;
;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    ubu_mode_type i_mode = UBU_MODE_UART;
    ubu_flow_type i_flow = UBU_FLOW_NONE;
    ubu_baud_type i_div = '{14'h0002, 3'h0};
    logic i_seven_bit = 1'b0, i_break = 1'b0, i_rts_set = 1'b0, i_dtr_set = 1'b0;
    logic [7:0] i_flush_ms = 8'h00, i_bb_dir = 8'hFF, i_out_data = 8'h00, i_bb = 8'h00;
    logic i_out_valid = 1'b0, i_in_req = 1'b0, i_send_now_wake_pin_n = 1'b1;
    ubu_modem_in_type i_modem_n = 4'hF;
    logic o_out_ready, o_in_valid, o_in_flush, o_txd, o_rts_n, o_dtr_n, o_line_driver_enable;
    logic o_break_seen, o_bb_wr_n, o_bb_rd_n, i_rxd, peer_valid;
    logic [7:0] o_in_data, o_bb, o_bb_oe, peer_data, b;
    logic [3:0] o_modem_status;
    logic [7:0] txq[$], rxq[$];
    int seed = 32'h67eb_a950;
    int miscompares = 0, check_count = 0;
    ubu_channel #(.MS_CYC(50)) dut_u (.i_mclk, .i_rst_n, .i_mode, .i_flow, .i_div,
        .i_seven_bit, .i_break, .i_rts_set, .i_dtr_set, .i_flush_ms, .i_bb_dir, .i_out_valid,
        .i_out_data, .o_out_ready, .i_in_req, .o_in_valid, .o_in_data, .o_in_flush, .o_txd,
        .i_rxd, .o_rts_n, .o_dtr_n, .i_modem_n, .o_line_driver_enable, .o_break_seen,
        .o_modem_status, .i_send_now_wake_pin_n, .i_bb, .o_bb, .o_bb_oe, .o_bb_wr_n, .o_bb_rd_n);
    ubu_peer #(.BIT_CYC(32)) peer_u (.i_mclk(i_mclk), .i_txd(o_txd), .i_seven(i_seven_bit),
        .o_rxd(i_rxd), .o_valid(peer_valid), .o_data(peer_data));
    // ----
    // Shared tasks
    // ----
    task automatic compare(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : compare
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : step
    // Valid stays up between pushes; the caller lowers it
    task automatic push(input logic [7:0] v);
        i_out_valid = 1'b1;
        i_out_data = v;
        txq.push_back(i_seven_bit ? {1'b0, v[6:0]} : v);
        while (o_out_ready !== 1'b1)
            step(1);
        step(1);
    endtask : push
    task automatic pop(input logic [7:0] v);
        rxq.push_back(v);
        i_in_req = 1'b1;
        step(1);
        i_in_req = 1'b0;
        step(1);
    endtask : pop
    task automatic summarize();
        miscompares += rxq.size();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ----
    // Monitor and sequence
    // ----
    initial
        forever #10 i_mclk = ~i_mclk;
    always @(posedge i_mclk)
    begin
        if (peer_valid === 1'b1 && txq.size() > 0)
            compare(peer_data, txq.pop_front(), "serial byte");
        if (o_in_valid === 1'b1 && rxq.size() > 0)
            compare(o_in_data, rxq.pop_front(), "in byte");
    end
    initial
    begin
        #200_000;
        miscompares++;
        summarize();
    end
    initial
    begin
        step(5);
        compare({o_txd, o_rts_n, o_dtr_n, o_out_ready}, 8'h0E, "reset levels");
        i_rst_n = 1'b1;
        step(2);
        for (int i = 0; i < 3; i++)
            push(8'($random(seed)));
        i_out_valid = 1'b0;
        while (txq.size() > 0)
            step(1);
        i_seven_bit = 1'b1;
        push(8'($random(seed)) | 8'h80);
        i_out_valid = 1'b0;
        while (txq.size() > 0)
            step(1);
        i_seven_bit = 1'b0;
        $display("transmit done");
        for (int i = 0; i < 3; i++)
        begin
            // Request on an empty store clears flush
            i_in_req = 1'b1;
            step(1);
            i_in_req = 1'b0;
            i_flush_ms = 8'(i / 2);
            step(1);
            compare(o_in_flush, 8'h00, "flush clear");
            b = 8'($random(seed));
            peer_u.send(b);
            step(64);
            i_send_now_wake_pin_n = (i != 2) ? 1'b0 : 1'b1;
            step(1);
            i_send_now_wake_pin_n = 1'b1;
            step(2);
            compare(o_in_flush, 8'h01, "flush");
            pop(b);
        end
        for (int i = 0; i < 4; i++)
        begin
            i_modem_n = 4'($random(seed));
            step(2);
            compare(o_modem_status, {4'h0, ~i_modem_n}, "modem");
        end
        $display("receive and modem done");
        i_bb_dir = 8'($random(seed));
        i_bb = 8'($random(seed));
        i_mode = UBU_MODE_ABB;
        for (int i = 0; i < 100 && o_bb_rd_n !== 1'b0; i++)
            step(1);
        step(2);
        pop(i_bb);
        b = 8'($random(seed));
        push(b);
        i_out_valid = 1'b0;
        for (int i = 0; i < 100 && o_bb_wr_n !== 1'b0; i++)
            step(1);
        compare(o_bb, b, "async out");
        compare(o_bb_oe, i_bb_dir, "oe");
        $display("async bit-bang done");
        i_mode = UBU_MODE_SBB;
        i_bb = 8'($random(seed));
        b = 8'($random(seed));
        push(b);
        i_out_valid = 1'b0;
        for (int i = 0; i < 400 && o_bb_wr_n !== 1'b0; i++)
            step(1);
        compare(o_bb, b, "port out");
        txq.delete();
        step(2);
        pop(i_bb);
        step(4);
        $display("sync bit-bang done");
        i_mode = UBU_MODE_UART;
        peer_u.set_line(1'b0);
        step(340);
        compare(o_break_seen, 8'h01, "break seen");
        peer_u.set_line(1'b1);
        step(400);
        compare(o_break_seen, 8'h00, "break cleared");
        $display("break done");
        summarize();
    end
endmodule : test_usb_bridge_uart_channel
`default_nettype wire
